// File: dv/cce_exec_tb.sv
// self-checking bench for the clear/complement execution unit
`timescale 1ns/1ps
module cce_exec_tb;
    import cce_pkg::*;

    logic                clk;
    logic                rstn;
    cce_apb_req_t        apbReq;
    logic [DATA_W-1:0]   prdata;
    logic                pready;
    logic                pslverr;
    logic [3:0]          progAddr;
    logic [INSTR_W-1:0]  progWord;
    int                  failCount;
    int                  samplesChecked;
    logic [DATA_W-1:0]   rd;
    logic [DATA_W-1:0]   p0;

    // ------------------------------------------------------------------
    // instances
    // ------------------------------------------------------------------
    cce_exec uut (
        .clk     (clk),
        .rstn    (rstn),
        .apbReq  (apbReq),
        .prdata  (prdata),
        .pready  (pready),
        .pslverr (pslverr)
    );

    cce_prog_mem prog (
        .addr (progAddr),
        .word (progWord)
    );

    // 25 ns period
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    task automatic conclude();
        $display("checks %0d mismatches %0d", samplesChecked, failCount);
        if (failCount == 0 && samplesChecked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : conclude

    task automatic check(input logic [31:0] got, input logic [31:0] exp,
                         input string what);
        samplesChecked++;
        if (got !== exp) begin
            failCount++;
            $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : check

    // one apb transfer; waits for pready under a bound
    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] d, output logic [31:0] r,
                       output logic err);
        int n;
        @(posedge clk);
        apbReq <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a,
                    pwdata: d};
        @(posedge clk);
        apbReq.penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) begin
            failCount++;
            $display("[FAIL] %0t pready never came", $time);
            conclude();
        end else begin
            r = prdata;
            err = pslverr;
            apbReq.psel <= 1'b0;
            apbReq.penable <= 1'b0;
        end
    endtask : apb

    task automatic wrReg(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic        e;
        apb(1'b1, a, d, r, e);
    endtask : wrReg

    task automatic rdReg(input logic [7:0] a, output logic [31:0] r);
        logic e;
        apb(1'b0, a, 32'h0000_0000, r, e);
    endtask : rdReg

    function automatic logic [7:0] fa(input int i);
        return OFF_FILE + 8'(i * 4);
    endfunction : fa

    // fetch one word from program memory and execute it
    task automatic run(input logic [3:0] k);
        progAddr = k;
        #1;
        wrReg(OFF_INSTR, {20'h00000, progWord});
    endtask : run

    // ------------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------------
    task automatic tResetMap();
        logic e;
        rdReg(OFF_STAT, rd);
        check(rd, 32'h0000_0018, "status after reset");
        rdReg(OFF_CTRL, rd);
        check(rd, 32'h0000_0000, "owner after reset");
        apb(1'b0, 8'h14, 32'h0000_0000, rd, e);
        check({31'h0, e}, 32'h1, "unmapped error");
        check(rd, 32'h0000_0000, "unmapped data");
    endtask : tResetMap

    task automatic tZeroFile();
        int idx [3] = '{0, 17, 31};
        wrReg(fa(1), 32'h33);
        for (int k = 0; k < 3; k++) begin
            wrReg(fa(idx[k]), 32'h5a);
            wrReg(OFF_STAT, 32'h0);
            run(4'(k));
            rdReg(fa(idx[k]), rd);
            check(rd, 32'h0, "cleared cell");
            rdReg(OFF_STAT, rd);
            check(rd & 32'h1, 32'h1, "zero flag set");
        end
        rdReg(fa(1), rd);
        check(rd, 32'h33, "neighbour cell kept");
    endtask : tZeroFile

    task automatic tInvert();
        wrReg(fa(5), 32'h13);
        wrReg(fa(31), 32'hff);
        wrReg(OFF_ACC, 32'h77);
        wrReg(OFF_STAT, 32'h1);
        run(4'h3);
        rdReg(OFF_ACC, rd);
        check(rd, 32'hec, "complement to acc");
        rdReg(fa(5), rd);
        check(rd, 32'h13, "cell kept when d=0");
        rdReg(OFF_STAT, rd);
        check(rd & 32'h1, 32'h0, "zero flag cleared");
        wrReg(OFF_ACC, 32'h55);
        run(4'h4);
        rdReg(fa(5), rd);
        check(rd, 32'hec, "complement to cell");
        rdReg(OFF_ACC, rd);
        check(rd, 32'h55, "acc kept when d=1");
        run(4'h5);
        rdReg(OFF_ACC, rd);
        check(rd, 32'h00, "complement of ff");
        rdReg(OFF_STAT, rd);
        check(rd & 32'h1, 32'h1, "zero flag on zero result");
    endtask : tInvert

    // prescaler counts each cycle; six edges lie between the two loads
    task automatic tKick();
        wrReg(OFF_CTRL, 32'h0);
        wrReg(OFF_STAT, 32'h1);
        rdReg(OFF_WDOG, p0);
        run(4'h6);
        rdReg(OFF_WDOG, rd);
        check({24'h0, rd[15:8] - p0[15:8]}, 32'h6, "timer prescaler");
        check({24'h0, rd[7:0]}, 32'h1, "counter restarted");
        rdReg(OFF_STAT, rd);
        check(rd, 32'h19, "status after kick");
        wrReg(OFF_CTRL, 32'h1);
        run(4'h6);
        rdReg(OFF_WDOG, rd);
        check({24'h0, rd[15:8]}, 32'h1, "owned prescaler");
        check(rd & 32'hff, 32'h0, "counter held at zero");
    endtask : tKick

    // ------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------
    initial begin
        failCount = 0;
        samplesChecked = 0;
        progAddr = 4'h0;
        rstn = 1'b0;
        apbReq = '0;
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        tResetMap();
        tZeroFile();
        tInvert();
        tKick();
        conclude();
    end

endmodule : cce_exec_tb

// File: dv/cce_prog_mem.sv
// program memory model that feeds instruction words to the bench
`timescale 1ns/1ps
module cce_prog_mem (
    input  wire logic [3:0]              addr, // word index
    output logic [cce_pkg::INSTR_W-1:0]  word  // instruction word
);
    import cce_pkg::*;

    // ------------------------------------------------------------------
    // fixed program
    // ------------------------------------------------------------------
    // spare slots hold a word that decodes to nothing, so a stray fetch
    // cannot pass for one of the three operations
    always_comb begin
        case (addr)
            4'h0:    word = 12'h060;
            4'h1:    word = 12'h071;
            4'h2:    word = 12'h07f;
            4'h3:    word = 12'h245;
            4'h4:    word = 12'h265;
            4'h5:    word = 12'h25f;
            4'h6:    word = 12'h004;
            default: word = 12'hfff;
        endcase
    end

endmodule : cce_prog_mem

// File: pkg/cce_pkg.sv
// shared types, offsets and decode helpers for the clear/complement unit
package cce_pkg;

    // ------------------------------------------------------------------
    // bus and data widths
    // ------------------------------------------------------------------
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int INSTR_W = 12;
    localparam int BYTE_W = 8;
    localparam int FILE_AW = 5;
    localparam int FILE_N = 32;

    // ------------------------------------------------------------------
    // register byte offsets
    // ------------------------------------------------------------------
    localparam logic [ADDR_W-1:0] OFF_INSTR = 8'h00;
    localparam logic [ADDR_W-1:0] OFF_ACC = 8'h04;
    localparam logic [ADDR_W-1:0] OFF_STAT = 8'h08;
    localparam logic [ADDR_W-1:0] OFF_CTRL = 8'h0c;
    localparam logic [ADDR_W-1:0] OFF_WDOG = 8'h10;
    localparam logic [ADDR_W-1:0] OFF_FILE = 8'h80;

    // ------------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------------
    localparam int STAT_ZERO_BIT = 0;
    localparam int STAT_SLEEP_BIT = 3;
    localparam int STAT_EXPIRY_BIT = 4;
    localparam int CTRL_PRES_BIT = 0;
    localparam int WDOG_PRES_LSB = 8;
    localparam int INSTR_DEST_BIT = 5;
    localparam int FILE_IDX_LSB = 2;

    // ------------------------------------------------------------------
    // instruction encodings
    // ------------------------------------------------------------------
    localparam logic [INSTR_W-1:0] ZERO_FILE_PAT = 12'h060;
    localparam logic [INSTR_W-1:0] ZERO_FILE_MSK = 12'hfe0;
    localparam logic [INSTR_W-1:0] KICK_PAT = 12'h004;
    localparam logic [INSTR_W-1:0] INVERT_PAT = 12'h240;
    localparam logic [INSTR_W-1:0] INVERT_MSK = 12'hfc0;

    // ------------------------------------------------------------------
    // reset values and constants
    // ------------------------------------------------------------------
    localparam logic [BYTE_W-1:0] BYTE_ZERO = 8'h00;
    localparam logic [BYTE_W-1:0] BYTE_ONE = 8'h01;
    localparam logic [BYTE_W-1:0] BYTE_FULL = 8'hff;
    localparam logic [DATA_W-1:0] WORD_ZERO = 32'h0000_0000;
    localparam logic RST_EXPIRY = 1'b1;
    localparam logic RST_SLEEP = 1'b1;
    localparam logic RST_PRES_TO_WDT = 1'b0;

    // ------------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------------
    typedef struct packed {
        logic              psel;
        logic              penable;
        logic              pwrite;
        logic [ADDR_W-1:0] paddr;
        logic [DATA_W-1:0] pwdata;
    } cce_apb_req_t;

    typedef struct packed {
        logic               en;
        logic [FILE_AW-1:0] addr;
        logic [BYTE_W-1:0]  data;
    } cce_file_wr_t;

    typedef struct packed {
        logic [FILE_N-1:0][BYTE_W-1:0] cells;
    } cce_file_t;

    typedef enum logic [2:0] {
        REG_INSTR = 3'b000,
        REG_ACC   = 3'b001,
        REG_STAT  = 3'b010,
        REG_CTRL  = 3'b011,
        REG_WDOG  = 3'b100,
        REG_FILE  = 3'b101,
        REG_NONE  = 3'b111
    } cce_reg_t;

    // ------------------------------------------------------------------
    // decoders, shared by execution and checks
    // ------------------------------------------------------------------
    function automatic logic isZeroFile(input logic [INSTR_W-1:0] w);
        return (w & ZERO_FILE_MSK) == ZERO_FILE_PAT;
    endfunction : isZeroFile

    function automatic logic isKick(input logic [INSTR_W-1:0] w);
        return w == KICK_PAT;
    endfunction : isKick

    function automatic logic isInvert(input logic [INSTR_W-1:0] w);
        return (w & INVERT_MSK) == INVERT_PAT;
    endfunction : isInvert

    function automatic cce_reg_t regSel(input logic [ADDR_W-1:0] a);
        if (a >= OFF_FILE) begin
            return REG_FILE;
        end
        case (a)
            OFF_INSTR: return REG_INSTR;
            OFF_ACC:   return REG_ACC;
            OFF_STAT:  return REG_STAT;
            OFF_CTRL:  return REG_CTRL;
            OFF_WDOG:  return REG_WDOG;
            default:   return REG_NONE;
        endcase
    endfunction : regSel

endpackage : cce_pkg

// File: verilog/cce_exec.sv
// execution of clear-file, watchdog-kick and complement-file instructions
// Function
// - clear-file writes zero, sets zero flag
// - file operand addresses registers 0 to 31
// - kick pattern clears the watchdog counter
// - kick clears prescaler only when watchdog-owned
// - kick sets expiry and sleep bits only
// - complement-file inverts register, updates zero flag
// - dest bit 0 to accumulator, 1 to register
`timescale 1ns/1ps
module cce_exec (
    input  wire logic                        clk,     // 40 MHz core clock
    input  wire logic                        rstn,    // async reset, low
    input  wire cce_pkg::cce_apb_req_t       apbReq,  // apb request
    output logic [cce_pkg::DATA_W-1:0]       prdata,  // apb read data
    output logic                             pready,  // apb ready
    output logic                             pslverr  // apb error
);
    import cce_pkg::*;

    // ------------------------------------------------------------------
    // block state
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [INSTR_W-1:0] lastInstr;
        logic [BYTE_W-1:0]  acc;
        logic               zeroFlag;
        logic               watchdogExpiryBit;
        logic               sleepEnteredBit;
        logic               presToWdt;
        logic [BYTE_W-1:0]  wdtCount;
        logic [BYTE_W-1:0]  presc;
        logic [DATA_W-1:0]  rdata;
    } cce_exec_state_t;

    cce_exec_state_t state_q;
    cce_exec_state_t state_d;

    cce_reg_t           sel;
    logic               setupPh;
    logic               writeAcc;
    logic               instrWr;
    logic [INSTR_W-1:0] instrWord;
    logic               zeroFileOp;
    logic               watchdogKickOp;
    logic               invertFileOp;
    logic               destReg;
    logic [FILE_AW-1:0] fileIdx;
    logic [FILE_AW-1:0] fileRdAddr;
    logic [BYTE_W-1:0]  fileRdData;
    logic [BYTE_W-1:0]  invResult;
    logic               wdtTick;
    cce_file_wr_t       fileWr;

    // ------------------------------------------------------------------
    // apb decode
    // ------------------------------------------------------------------
    assign sel = regSel(apbReq.paddr);
    assign setupPh = apbReq.psel && !apbReq.penable;
    assign writeAcc = apbReq.psel && apbReq.penable && apbReq.pwrite;
    assign pready = 1'b1; // zero wait states, every access ends at once
    assign pslverr = apbReq.psel && apbReq.penable && (sel == REG_NONE);
    assign prdata = state_q.rdata;

    // ------------------------------------------------------------------
    // instruction decode; a write to the instruction port executes it
    // ------------------------------------------------------------------
    assign instrWr = writeAcc && (sel == REG_INSTR);
    assign instrWord = apbReq.pwdata[INSTR_W-1:0];
    assign zeroFileOp = instrWr && isZeroFile(instrWord);
    assign watchdogKickOp = instrWr && isKick(instrWord);
    assign invertFileOp = instrWr && isInvert(instrWord);
    assign destReg = instrWord[INSTR_DEST_BIT];
    assign fileIdx = instrWord[FILE_AW-1:0];

    // file read port: instruction operand wins, only one transfer at once
    assign fileRdAddr = instrWr ? fileIdx
                      : apbReq.paddr[FILE_IDX_LSB +: FILE_AW];
    assign invResult = ~fileRdData;

    // ------------------------------------------------------------------
    // file write port: instructions and direct software writes
    // ------------------------------------------------------------------
    always_comb begin
        fileWr = '0;
        if (zeroFileOp) begin
            fileWr.en = 1'b1;
            fileWr.addr = fileIdx;
            fileWr.data = BYTE_ZERO;
        end else if (invertFileOp && destReg) begin
            fileWr.en = 1'b1;
            fileWr.addr = fileIdx;
            fileWr.data = invResult;
        end else if (writeAcc && sel == REG_FILE) begin
            fileWr.en = 1'b1;
            fileWr.addr = apbReq.paddr[FILE_IDX_LSB +: FILE_AW];
            fileWr.data = apbReq.pwdata[BYTE_W-1:0];
        end
    end

    cce_file_regs u_file (
        .clk    (clk),
        .rstn   (rstn),
        .wr     (fileWr),
        .rdAddr (fileRdAddr),
        .rdData (fileRdData)
    );

    // watchdog advances each cycle, or once per prescaler wrap if owned
    assign wdtTick = state_q.presToWdt ? (state_q.presc == BYTE_FULL)
                                        : 1'b1;

    // ------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------
    always_comb begin
        state_d = state_q;

        // free-running divider and watchdog counter
        state_d.presc = state_q.presc + BYTE_ONE;
        if (wdtTick) begin
            state_d.wdtCount = state_q.wdtCount + BYTE_ONE;
        end

        // software writes to accumulator, control, status and instruction registers
        if (writeAcc) begin
            case (sel)
                REG_ACC: begin
                    state_d.acc = apbReq.pwdata[BYTE_W-1:0];
                end
                REG_STAT: begin
                    state_d.zeroFlag = apbReq.pwdata[STAT_ZERO_BIT];
                    state_d.sleepEnteredBit = apbReq.pwdata[STAT_SLEEP_BIT];
                    state_d.watchdogExpiryBit =
                        apbReq.pwdata[STAT_EXPIRY_BIT];
                end
                REG_CTRL: begin
                    state_d.presToWdt = apbReq.pwdata[CTRL_PRES_BIT];
                end
                REG_INSTR: begin
                    state_d.lastInstr = instrWord;
                end
                default: begin
                end
            endcase
        end

        // timeout after the software write: a same-cycle write of the
        // status register must not hide an expiry
        if (wdtTick && state_q.wdtCount == BYTE_FULL) begin
            state_d.watchdogExpiryBit = 1'b0; // timeout, active low
        end

        // instruction effects, last so they win over background counting
        if (zeroFileOp) begin
            state_d.zeroFlag = 1'b1;
        end
        if (watchdogKickOp) begin
            state_d.wdtCount = BYTE_ZERO;
            if (state_q.presToWdt) begin
                state_d.presc = BYTE_ZERO;
            end
            state_d.watchdogExpiryBit = 1'b1;
            state_d.sleepEnteredBit = 1'b1;
        end
        if (invertFileOp) begin
            state_d.zeroFlag = (invResult == BYTE_ZERO);
            if (!destReg) begin
                state_d.acc = invResult;
            end
        end

        // read data captured in the setup cycle, so prdata is a flop
        if (setupPh && !apbReq.pwrite) begin
            state_d.rdata = WORD_ZERO;
            case (sel)
                REG_INSTR: state_d.rdata[INSTR_W-1:0] = state_q.lastInstr;
                REG_ACC:   state_d.rdata[BYTE_W-1:0] = state_q.acc;
                REG_STAT: begin
                    state_d.rdata[STAT_ZERO_BIT] = state_q.zeroFlag;
                    state_d.rdata[STAT_SLEEP_BIT] = state_q.sleepEnteredBit;
                    state_d.rdata[STAT_EXPIRY_BIT] =
                        state_q.watchdogExpiryBit;
                end
                REG_CTRL:  state_d.rdata[CTRL_PRES_BIT] = state_q.presToWdt;
                REG_WDOG: begin
                    state_d.rdata[BYTE_W-1:0] = state_q.wdtCount;
                    state_d.rdata[WDOG_PRES_LSB +: BYTE_W] = state_q.presc;
                end
                REG_FILE:  state_d.rdata[BYTE_W-1:0] = fileRdData;
                default:   state_d.rdata = WORD_ZERO;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // state register
    // ------------------------------------------------------------------
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state_q <= '0;
            state_q.watchdogExpiryBit <= RST_EXPIRY;
            state_q.sleepEnteredBit <= RST_SLEEP;
            state_q.presToWdt <= RST_PRES_TO_WDT;
        end else begin
            state_q <= state_d;
        end
    end

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    sequence s_kick;
        watchdogKickOp;
    endsequence

    sequence s_kick_done;
        state_q.wdtCount == BYTE_ZERO && state_q.watchdogExpiryBit
            && state_q.sleepEnteredBit;
    endsequence

    property p_zero_file;
        zeroFileOp |-> fileWr.en && fileWr.data == BYTE_ZERO
            ##1 state_q.zeroFlag;
    endproperty
    a_zero_file: assert property (p_zero_file)
        else $error("clear-file did not zero register and set flag");

    property p_file_addr;
        (zeroFileOp || (invertFileOp && destReg))
            |-> fileWr.addr == apbReq.pwdata[FILE_AW-1:0];
    endproperty
    a_file_addr: assert property (p_file_addr)
        else $error("file write went to wrong register");

    property p_kick_count;
        s_kick |=> state_q.wdtCount == BYTE_ZERO;
    endproperty
    a_kick_count: assert property (p_kick_count)
        else $error("kick did not clear watchdog counter");

    property p_kick_presc;
        s_kick |=> state_q.presc == ($past(state_q.presToWdt) ? BYTE_ZERO
            : BYTE_W'($past(state_q.presc) + BYTE_ONE));
    endproperty
    a_kick_presc: assert property (p_kick_presc)
        else $error("prescaler handling on kick is wrong");

    property p_kick_status;
        s_kick |=> s_kick_done
            and state_q.zeroFlag == $past(state_q.zeroFlag);
    endproperty
    a_kick_status: assert property (p_kick_status)
        else $error("kick status bits wrong");

    property p_invert_data;
        invertFileOp && destReg |-> fileWr.data == ~fileRdData
            ##1 state_q.acc == $past(state_q.acc);
    endproperty
    a_invert_data: assert property (p_invert_data)
        else $error("complement to register wrong");

    property p_invert_acc;
        invertFileOp && !destReg |-> !fileWr.en
            ##1 state_q.acc == ~$past(fileRdData);
    endproperty
    a_invert_acc: assert property (p_invert_acc)
        else $error("complement to accumulator wrong");

    property p_invert_zero;
        invertFileOp |=> state_q.zeroFlag == ($past(fileRdData) == BYTE_FULL);
    endproperty
    a_invert_zero: assert property (p_invert_zero)
        else $error("zero flag after complement wrong");

    // operand picks the file read port during an instruction write
    property p_operand_read;
        instrWr |-> fileRdAddr == apbReq.pwdata[FILE_AW-1:0];
    endproperty
    a_operand_read: assert property (p_operand_read)
        else $error("operand did not select the file read port");

    // kick touches neither data file nor accumulator
    property p_kick_quiet;
        s_kick |-> !fileWr.en ##1 state_q.acc == $past(state_q.acc);
    endproperty
    a_kick_quiet: assert property (p_kick_quiet)
        else $error("kick disturbed file or accumulator");

    // clearing a register leaves the accumulator alone
    property p_zero_acc_kept;
        zeroFileOp |=> state_q.acc == $past(state_q.acc);
    endproperty
    a_zero_acc_kept: assert property (p_zero_acc_kept)
        else $error("clear-file changed the accumulator");

endmodule : cce_exec

// File: verilog/cce_file_regs.sv
// bank of 32 eight-bit data registers, one write port, one read port
`timescale 1ns/1ps
module cce_file_regs (
    input  wire logic                         clk,    // core clock
    input  wire logic                         rstn,   // async reset, low
    input  wire cce_pkg::cce_file_wr_t        wr,     // write request
    input  wire logic [cce_pkg::FILE_AW-1:0]  rdAddr, // read index
    output logic [cce_pkg::BYTE_W-1:0]        rdData  // read value
);
    import cce_pkg::*;

    cce_file_t state_q;
    cce_file_t state_d;

    // ------------------------------------------------------------------
    // next state: one cell written per cycle
    // ------------------------------------------------------------------
    always_comb begin
        state_d = state_q;
        if (wr.en) begin
            state_d.cells[wr.addr] = wr.data;
        end
    end

    // ------------------------------------------------------------------
    // state register
    // ------------------------------------------------------------------
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state_q <= '0;
        end else begin
            state_q <= state_d;
        end
    end

    // read is from flops, so a write shows on the next cycle
    assign rdData = state_q.cells[rdAddr];

endmodule : cce_file_regs
